// ### seq_pkg.sv
// constants and types shared by the dual rail power sequencer
`default_nettype none
package seq_pkg;
    // capacitor discharge one-shot length in clock cycles
    localparam int unsigned DISCHARGE_CYCLES = 16;
    localparam int unsigned COUNT_WIDTH      = 8;
    // order_select levels
    localparam logic ORDER_CORE_FIRST = 1'b0;
    localparam logic ORDER_IO_FIRST   = 1'b1;
    // reset level of two-flop synchroniser stages
    localparam logic SYNC_RESET_LEVEL = 1'b0;

    typedef enum logic [3:0] {
        ST_IDLE      = 4'b0000,
        ST_DISCH1    = 4'b0001,
        ST_RAMP1     = 4'b0010,
        ST_DELAY1    = 4'b0011,
        ST_DISCH2    = 4'b0100,
        ST_RAMP2     = 4'b0101,
        ST_DELAY2    = 4'b0110,
        ST_RUN       = 4'b0111,
        ST_DOWN2     = 4'b1000,
        ST_DOWN1     = 4'b1001
    } seq_state_type;
endpackage
`default_nettype wire

// ### sync2.sv
// two flip-flop synchroniser for asynchronous status levels
`default_nettype none
module sync2 #(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // asynchronous in, synchronous out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    import seq_pkg::*;

    logic [WIDTH-1:0] first_reg;
    logic [WIDTH-1:0] second_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            first_reg  <= {WIDTH{SYNC_RESET_LEVEL}};
            second_reg <= {WIDTH{SYNC_RESET_LEVEL}};
        end else begin
            first_reg  <= async_in;
            second_reg <= first_reg;
        end
    end

    assign sync_out = second_reg;
endmodule
`default_nettype wire

// ### dual_rail_power_sequencer.sv
// dual rail power sequencer state machine with rail enables and power-good
//
// Operation
// R1: internal enable is enable AND undervoltage ok
// R2: idle with rails off until enabled
// R3: enable rise: discharge ramp1, then rail one on
// R4: first rail above threshold starts delay one
// R5: delay one done: discharge ramp2, rail two on
// R6: second rail above threshold starts delay two
// R7: delay two done raises power-good, held
// R8: enable fall: power-good low, second rail off
// R9: pull-down active while rail enable low
// R10: first rail off after other below threshold
// R11: idle after last rail below threshold
// R12: order_select low core first, high io first
// R13: overtemperature forces both enables off
// R14: overtemperature release restarts full power-up
// R15: aux detect follows aux comparator only
// R16: power-down done only when both below threshold
// R17: pull-down is inverse of rail enable
// R18: asynchronous status inputs pass two flops
// R19: discharge one-shot lasts fixed cycle count
`default_nettype none
module dual_rail_power_sequencer #(
    parameter int unsigned DISCHARGE_LEN = seq_pkg::DISCHARGE_CYCLES
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // enable and protection status
    input  wire logic enable_in,
    input  wire logic input_undervoltage_ok,
    input  wire logic overtemp_shutdown,
    input  wire logic order_select,
    // comparator and delay threshold status
    input  wire logic core_above_threshold,
    input  wire logic io_above_threshold,
    input  wire logic core_below_off_threshold,
    input  wire logic io_below_off_threshold,
    input  wire logic delay1_threshold,
    input  wire logic delay2_threshold,
    input  wire logic aux_comparator,
    // rail controls
    output logic      core_rail_on,
    output logic      io_rail_on,
    output logic      core_rail_pulldown,
    output logic      io_rail_pulldown,
    output logic      ramp1_discharge,
    output logic      ramp2_discharge,
    output logic      delay1_start,
    output logic      delay2_start,
    // system outputs
    output logic      supply_ok_out,
    output logic      aux_detect_out,
    output logic      seq_idle
);
    import seq_pkg::*;

    // number of status levels carried through the synchroniser
    localparam int unsigned NSYNC = 11;

    typedef struct packed {
        seq_state_type          state;
        logic [COUNT_WIDTH-1:0] count;
        logic                   first_io;
        logic                   rail1_on;
        logic                   rail2_on;
        logic                   disch1;
        logic                   disch2;
        logic                   dly1;
        logic                   dly2;
        logic                   supply_ok;
        logic                   aux;
        logic                   core_on;
        logic                   io_on;
        logic                   core_pd;
        logic                   io_pd;
        logic                   idle;
    } seq_regs_type;

    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] sync_in;
    seq_regs_type     cur_reg;
    seq_regs_type     cur_next;

    // synchronised status levels
    logic en_s;
    logic ok_s;
    logic tsd_s;
    logic order_s;
    logic core_up_s;
    logic io_up_s;
    logic core_dn_s;
    logic io_dn_s;
    logic dly1_s;
    logic dly2_s;
    logic aux_s;
    // internal enable and order-mapped status
    logic int_enable;
    logic rail1_up;
    logic rail2_up;
    logic rail1_down;
    logic rail2_down;
    logic [COUNT_WIDTH-1:0] disch_last;
    logic up_phase;

    // all asynchronous status through two flops
    assign raw_in = {enable_in,
                     input_undervoltage_ok,
                     overtemp_shutdown,
                     order_select,
                     core_above_threshold,
                     io_above_threshold,
                     core_below_off_threshold,
                     io_below_off_threshold,
                     delay1_threshold,
                     delay2_threshold,
                     aux_comparator};

    sync2 #(
        .WIDTH (NSYNC)
    ) u_sync (
        .clk      (clk),
        .arst_n   (arst_n),
        .async_in (raw_in),
        .sync_out (sync_in)
    ); // see R18

    assign {en_s,
            ok_s,
            tsd_s,
            order_s,
            core_up_s,
            io_up_s,
            core_dn_s,
            io_dn_s,
            dly1_s,
            dly2_s,
            aux_s} = sync_in;

    // internal enable and order-mapped rail status
    assign int_enable = en_s & ok_s; // see R1
    assign rail1_up   = cur_reg.first_io ? io_up_s : core_up_s; // see R12
    assign rail2_up   = cur_reg.first_io ? core_up_s : io_up_s;
    assign rail1_down = cur_reg.first_io ? io_dn_s : core_dn_s;
    assign rail2_down = cur_reg.first_io ? core_dn_s : io_dn_s;
    assign disch_last = COUNT_WIDTH'(DISCHARGE_LEN - 1);
    // states in which enable loss starts power-down
    assign up_phase   = (cur_reg.state != ST_IDLE) && (cur_reg.state != ST_DOWN2) && (cur_reg.state != ST_DOWN1);

    // next-state logic
    always_comb begin
        cur_next           = cur_reg;
        cur_next.aux       = aux_s; // see R15
        cur_next.dly1      = 1'b0;
        cur_next.dly2      = 1'b0;
        case (cur_reg.state)
            // waiting for the internal enable
            ST_IDLE: begin
                cur_next.rail1_on  = 1'b0; // see R2
                cur_next.rail2_on  = 1'b0;
                cur_next.supply_ok = 1'b0;
                // start only with both rails below the off threshold
                if (int_enable && !tsd_s && core_dn_s && io_dn_s) begin // see R16
                    cur_next.first_io = (order_s == ORDER_IO_FIRST); // see R12
                    cur_next.disch1   = 1'b1; // see R3
                    cur_next.count    = '0;
                    cur_next.state    = ST_DISCH1;
                end
            end
            // first ramp capacitor discharge one-shot
            ST_DISCH1: begin
                cur_next.count = cur_reg.count + COUNT_WIDTH'(1);
                if (cur_reg.count == disch_last) begin
                    cur_next.disch1   = 1'b0; // see R19
                    cur_next.rail1_on = 1'b1; // see R3
                    cur_next.state    = ST_RAMP1;
                end
            end
            // first rail ramping up
            ST_RAMP1: begin
                if (rail1_up) begin
                    cur_next.dly1  = 1'b1; // see R4
                    cur_next.state = ST_DELAY1;
                end
            end
            // first supervisor delay running
            ST_DELAY1: begin
                if (dly1_s) begin
                    cur_next.disch2 = 1'b1; // see R5
                    cur_next.count  = '0;
                    cur_next.state  = ST_DISCH2;
                end
            end
            // second ramp capacitor discharge one-shot
            ST_DISCH2: begin
                cur_next.count = cur_reg.count + COUNT_WIDTH'(1);
                if (cur_reg.count == disch_last) begin
                    cur_next.disch2   = 1'b0; // see R19
                    cur_next.rail2_on = 1'b1; // see R5
                    cur_next.state    = ST_RAMP2;
                end
            end
            // second rail ramping up
            ST_RAMP2: begin
                if (rail2_up) begin
                    cur_next.dly2  = 1'b1; // see R6
                    cur_next.state = ST_DELAY2;
                end
            end
            // second supervisor delay running
            ST_DELAY2: begin
                if (dly2_s) begin
                    cur_next.supply_ok = 1'b1; // see R7
                    cur_next.state     = ST_RUN;
                end
            end
            // both rails up, power-good held
            ST_RUN: begin
                cur_next.supply_ok = 1'b1; // see R7
            end
            // second rail off, wait for it to fall
            ST_DOWN2: begin
                cur_next.supply_ok = 1'b0;
                cur_next.rail2_on  = 1'b0;
                if (rail2_down) begin
                    cur_next.rail1_on = 1'b0; // see R10
                    cur_next.state    = ST_DOWN1;
                end
            end
            // first rail off, wait for both to fall
            ST_DOWN1: begin
                cur_next.rail1_on = 1'b0;
                if (rail1_down && rail2_down) begin
                    cur_next.state = ST_IDLE; // see R11 R16
                end
            end
            // unused codes recover to idle
            default: begin
                cur_next.state = ST_IDLE;
            end
        endcase

        // enable loss from any active state starts power-down
        if (up_phase && !int_enable) begin
            cur_next.supply_ok = 1'b0; // see R8
            cur_next.rail2_on  = 1'b0; // see R8
            cur_next.disch1    = 1'b0;
            cur_next.disch2    = 1'b0;
            cur_next.state     = ST_DOWN2;
        end
        // overtemperature kills both rails; release restarts from idle
        if (tsd_s) begin
            cur_next.rail1_on  = 1'b0; // see R13
            cur_next.rail2_on  = 1'b0; // see R13
            cur_next.supply_ok = 1'b0;
            cur_next.disch1    = 1'b0;
            cur_next.disch2    = 1'b0;
            cur_next.state     = ST_IDLE; // see R14
        end

        // map sequence positions onto the physical rails
        if (cur_next.first_io) begin
            cur_next.core_on = cur_next.rail2_on; // see R12
            cur_next.io_on   = cur_next.rail1_on;
        end else begin
            cur_next.core_on = cur_next.rail1_on;
            cur_next.io_on   = cur_next.rail2_on;
        end
        // pull-downs registered as the inverse of the enables
        cur_next.core_pd = ~cur_next.core_on; // see R9 R17
        cur_next.io_pd   = ~cur_next.io_on;
        // idle flag registered alongside the state
        cur_next.idle    = (cur_next.state == ST_IDLE);
    end

    // state register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cur_reg <= '{state: ST_IDLE, core_pd: 1'b1, io_pd: 1'b1, idle: 1'b1, default: '0};
        end else begin
            cur_reg <= cur_next;
        end
    end

    // rail enables and pull-downs straight from flops
    assign core_rail_on       = cur_reg.core_on; // see R12
    assign io_rail_on         = cur_reg.io_on;
    assign core_rail_pulldown = cur_reg.core_pd; // see R9 R17
    assign io_rail_pulldown   = cur_reg.io_pd; // see R9 R17

    // one-shots and delay start pulses
    assign ramp1_discharge    = cur_reg.disch1;
    assign ramp2_discharge    = cur_reg.disch2;
    assign delay1_start       = cur_reg.dly1;
    assign delay2_start       = cur_reg.dly2;

    // status outputs
    assign supply_ok_out      = cur_reg.supply_ok;
    assign aux_detect_out     = cur_reg.aux;
    assign seq_idle           = cur_reg.idle;
endmodule
`default_nettype wire

// ### seq_props.sv
// port checker for the dual rail power sequencer
`default_nettype none
module seq_props
    import seq_pkg::*;
#(parameter int unsigned DISCHARGE_LEN = 16) (
    // every port of the sequencer, watched only
    input wire logic clk, arst_n, enable_in, input_undervoltage_ok, overtemp_shutdown, order_select,
    input wire logic core_above_threshold, io_above_threshold, core_below_off_threshold,
    input wire logic io_below_off_threshold, delay1_threshold, delay2_threshold, aux_comparator,
    input wire logic core_rail_on, io_rail_on, core_rail_pulldown, io_rail_pulldown, ramp1_discharge,
    input wire logic ramp2_discharge, delay1_start, delay2_start, supply_ok_out, aux_detect_out, seq_idle
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] cnt_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // length of the current discharge pulse
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            cnt_reg <= 8'h00;
        else
            cnt_reg <= (ramp1_discharge | ramp2_discharge) ? cnt_reg + 8'h01 : 8'h00;
    end
    property p_pd; core_rail_pulldown == !core_rail_on && io_rail_pulldown == !io_rail_on; endproperty
    a_pd: assert property (p_pd) else $error("pulldown");
    property p_idle; seq_idle |-> !core_rail_on && !io_rail_on && !supply_ok_out; endproperty
    a_idle: assert property (p_idle) else $error("idle");
    property p_tsd; overtemp_shutdown [*3] |=> !core_rail_on && !io_rail_on && !supply_ok_out; endproperty
    a_tsd: assert property (p_tsd) else $error("tsd");
    property p_dis;
        (supply_ok_out && !(enable_in && input_undervoltage_ok)) [*3] |=> !supply_ok_out && (core_rail_on ^ io_rail_on);
    endproperty
    a_dis: assert property (p_dis) else $error("disable");
    property p_ok; $rose(supply_ok_out) |-> $past(delay2_threshold, 3); endproperty
    a_ok: assert property (p_ok) else $error("ok");
    property p_len; $fell(ramp1_discharge | ramp2_discharge) |-> cnt_reg == DISCHARGE_LEN; endproperty
    a_len: assert property (p_len) else $error("len");
    property p_on; $fell(ramp1_discharge) |-> core_rail_on || io_rail_on; endproperty
    a_on: assert property (p_on) else $error("on");
    property p_io1; $rose(io_rail_on) && !core_rail_on |-> order_select == ORDER_IO_FIRST; endproperty
    a_io1: assert property (p_io1) else $error("io");
    property p_co1; $rose(core_rail_on) && !io_rail_on |-> order_select == ORDER_CORE_FIRST; endproperty
    a_co1: assert property (p_co1) else $error("core");
    property p_last; $fell(core_rail_on) && !$past(io_rail_on) |-> $past(io_below_off_threshold, 3); endproperty
    a_last: assert property (p_last) else $error("last");
    property p_aux; aux_detect_out == $past(aux_comparator, 3); endproperty
    a_aux: assert property (p_aux) else $error("aux");
    // main scenarios reached
    cover property ($rose(supply_ok_out));
    cover property ($fell(core_rail_on) && !io_rail_on);
    cover property (overtemp_shutdown [*3] ##1 !io_rail_on);
endmodule
bind dual_rail_power_sequencer seq_props #(.DISCHARGE_LEN(DISCHARGE_LEN)) u_props (
    .clk(clk), .arst_n(arst_n), .enable_in(enable_in), .input_undervoltage_ok(input_undervoltage_ok),
    .overtemp_shutdown(overtemp_shutdown), .order_select(order_select), .aux_comparator(aux_comparator),
    .core_above_threshold(core_above_threshold), .io_above_threshold(io_above_threshold),
    .core_below_off_threshold(core_below_off_threshold), .io_below_off_threshold(io_below_off_threshold),
    .delay1_threshold(delay1_threshold), .delay2_threshold(delay2_threshold),
    .core_rail_on(core_rail_on), .io_rail_on(io_rail_on), .core_rail_pulldown(core_rail_pulldown),
    .io_rail_pulldown(io_rail_pulldown), .ramp1_discharge(ramp1_discharge), .ramp2_discharge(ramp2_discharge),
    .delay1_start(delay1_start), .delay2_start(delay2_start), .supply_ok_out(supply_ok_out),
    .aux_detect_out(aux_detect_out), .seq_idle(seq_idle));
`default_nettype wire

// ### rail_model.sv
// behavioural rails, supervisors and delay capacitors on the far side
`default_nettype none
module rail_model #(parameter int RAMP = 6, parameter int DLY = 5) (
    // rail controls in
    input wire logic clk, core_rail_on, io_rail_on, ramp1_discharge, delay1_start, delay2_start,
    // comparator and delay status out
    output logic core_above_threshold, io_above_threshold, core_below_off_threshold,
    output logic io_below_off_threshold, delay1_threshold, delay2_threshold
);
    timeunit 1ns;
    timeprecision 100ps;
    int v1 = 0;
    int v2 = 0;
    int d1 = 0;
    int d2 = 0;
    // rails ramp up while enabled and fall through the pull-down
    always @(posedge clk) begin
        v1 <= core_rail_on ? (v1 < RAMP ? v1 + 1 : v1) : (v1 > 0 ? v1 - 1 : 0);
        v2 <= io_rail_on ? (v2 < RAMP ? v2 + 1 : v2) : (v2 > 0 ? v2 - 1 : 0);
        d1 <= ramp1_discharge ? 0 : delay1_start ? 1 : (d1 > 0 && d1 < DLY) ? d1 + 1 : d1;
        d2 <= ramp1_discharge ? 0 : delay2_start ? 1 : (d2 > 0 && d2 < DLY) ? d2 + 1 : d2;
    end
    // threshold comparators
    assign core_above_threshold = v1 == RAMP;
    assign io_above_threshold = v2 == RAMP;
    assign core_below_off_threshold = v1 == 0;
    assign io_below_off_threshold = v2 == 0;
    assign delay1_threshold = d1 == DLY;
    assign delay2_threshold = d2 == DLY;
endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench for the dual rail power sequencer
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int DL = 4;
    logic clk = 1'b0, arst_n = 1'b0, enable_in = 1'b0, input_undervoltage_ok = 1'b0;
    logic overtemp_shutdown = 1'b0, order_select = 1'b0, aux_comparator = 1'b0;
    logic core_above_threshold, io_above_threshold, core_below_off_threshold, io_below_off_threshold;
    logic delay1_threshold, delay2_threshold, core_rail_on, io_rail_on, core_rail_pulldown, io_rail_pulldown;
    logic ramp1_discharge, ramp2_discharge, delay1_start, delay2_start, supply_ok_out, aux_detect_out, seq_idle;
    int bad_count = 0;
    int n_compared = 0;
    dual_rail_power_sequencer #(.DISCHARGE_LEN(DL)) u_dut (
        .clk(clk), .arst_n(arst_n), .enable_in(enable_in), .input_undervoltage_ok(input_undervoltage_ok),
        .overtemp_shutdown(overtemp_shutdown), .order_select(order_select), .aux_comparator(aux_comparator),
        .core_above_threshold(core_above_threshold), .io_above_threshold(io_above_threshold),
        .core_below_off_threshold(core_below_off_threshold), .io_below_off_threshold(io_below_off_threshold),
        .delay1_threshold(delay1_threshold), .delay2_threshold(delay2_threshold),
        .core_rail_on(core_rail_on), .io_rail_on(io_rail_on), .core_rail_pulldown(core_rail_pulldown),
        .io_rail_pulldown(io_rail_pulldown), .ramp1_discharge(ramp1_discharge),
        .ramp2_discharge(ramp2_discharge), .delay1_start(delay1_start), .delay2_start(delay2_start),
        .supply_ok_out(supply_ok_out), .aux_detect_out(aux_detect_out), .seq_idle(seq_idle));
    rail_model u_model (
        .clk(clk), .core_rail_on(core_rail_on), .io_rail_on(io_rail_on), .ramp1_discharge(ramp1_discharge),
        .delay1_start(delay1_start), .delay2_start(delay2_start), .core_above_threshold(core_above_threshold),
        .io_above_threshold(io_above_threshold), .core_below_off_threshold(core_below_off_threshold),
        .io_below_off_threshold(io_below_off_threshold), .delay1_threshold(delay1_threshold),
        .delay2_threshold(delay2_threshold));
    // 40 MHz clock
    initial forever #12.5 clk = ~clk;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results;
        if (bad_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // power-up in the given order, checking discharge length and rail order
    task automatic t_up(input logic ord);
        int i;
        int n;
        int p1;
        int p2;
        int m;
        order_select = ord;
        enable_in = 1'b1;
        input_undervoltage_ok = 1'b1;
        for (i = 0; i < 50 && ramp1_discharge !== 1'b1; i++) @(negedge clk);
        for (n = 0; n < 20 && ramp1_discharge === 1'b1; n++) @(negedge clk);
        check(8'(n), 8'(DL));
        check(8'({core_rail_on, io_rail_on, core_rail_pulldown, io_rail_pulldown}), ord ? 8'h06 : 8'h09);
        p1 = 0;
        p2 = 0;
        m = 0;
        for (i = 0; i < 300 && supply_ok_out !== 1'b1; i++) begin
            @(negedge clk);
            p1 += (delay1_start === 1'b1) ? 1 : 0;
            p2 += (delay2_start === 1'b1) ? 1 : 0;
            m += (ramp2_discharge === 1'b1) ? 1 : 0;
        end
        check(8'(p1), 8'h01);
        check(8'(m), 8'(DL));
        check(8'(p2), 8'h01);
        check(8'({supply_ok_out, core_rail_on, io_rail_on}), 8'h07);
    endtask
    // power-down by enable or by input undervoltage
    task automatic t_down(input logic by_input_undervoltage_ok);
        int i;
        if (by_input_undervoltage_ok)
            input_undervoltage_ok = 1'b0;
        else
            enable_in = 1'b0;
        tick(4);
        check(8'({supply_ok_out, core_rail_on, io_rail_on}), order_select ? 8'h01 : 8'h02);
        for (i = 0; i < 300 && seq_idle !== 1'b1; i++) @(negedge clk);
        check(8'({seq_idle, core_rail_on, io_rail_on, core_rail_pulldown, io_rail_pulldown}), 8'h13);
    endtask
    // thermal shutdown while running, then restart
    task automatic t_tsd;
        overtemp_shutdown = 1'b1;
        tick(4);
        check(8'({supply_ok_out, core_rail_on, io_rail_on}), 8'h00);
        tick(20);
        overtemp_shutdown = 1'b0;
        t_up(order_select);
    endtask
    // aux detect follows its comparator
    task automatic t_aux;
        aux_comparator = 1'b1;
        tick(4);
        check(8'(aux_detect_out), 8'h01);
        aux_comparator = 1'b0;
        tick(4);
        check(8'(aux_detect_out), 8'h00);
    endtask
    // main sequence
    initial begin
        tick(16);
        arst_n = 1'b1;
        tick(4);
        check(8'({seq_idle, core_rail_on, io_rail_on, supply_ok_out}), 8'h08);
        enable_in = 1'b1;
        tick(8);
        check(8'({seq_idle, ramp1_discharge}), 8'h02);
        t_up(1'b0);
        t_down(1'b0);
        t_up(1'b1);
        t_down(1'b1);
        t_up(1'b0);
        t_tsd();
        t_down(1'b0);
        t_aux();
        results();
    end
    // watchdog
    initial begin
        #125us;
        bad_count++;
        results();
    end
endmodule
`default_nettype wire
